//--- src/dbw_pkg.sv
// downstream window register bank: shared offsets, fields, resets and states
// assumes a 32-bit register bus with byte addresses and one aligned word per register
package dbw_pkg;

  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [7:0] DBW_OFF_WIN1_BAR   = 8'h18;
  localparam logic [7:0] DBW_OFF_WIN2_BAR   = 8'h1C;
  localparam logic [7:0] DBW_OFF_WIN1_XLATE = 8'hA8;
  localparam logic [7:0] DBW_OFF_WIN1_SETUP = 8'hAC;
  localparam logic [7:0] DBW_OFF_WIN2_XLATE = 8'hB8;
  localparam logic [7:0] DBW_OFF_WIN2_SETUP = 8'hBC;

  // ****************************************
  // field positions
  // ****************************************
  localparam int DBW_BIT_SPACE    = 0;
  localparam int DBW_BIT_ATYPE_LO = 1;
  localparam int DBW_BIT_PREF     = 3;
  localparam int DBW_BIT_IOLEN_LO = 6;
  localparam int DBW_BIT_BASE_LO  = 12;
  localparam int DBW_BIT_ENABLE   = 31;
  localparam int DBW_BASE_W       = 20;

  // ****************************************
  // codes and reset values
  // ****************************************
  localparam logic [1:0]  DBW_ATYPE_32    = 2'h0;
  localparam logic [1:0]  DBW_ATYPE_64    = 2'h1;
  localparam logic [31:0] DBW_RST_SETUP   = 32'h0000_0000;
  localparam logic [31:0] DBW_RST_XLATE   = 32'h0000_0000;
  localparam logic [19:0] DBW_RST_BASE    = 20'h0_0000;
  localparam logic [31:0] DBW_RD_NONE     = 32'h0000_0000;
  localparam int          DBW_IO_MIN_LOG2 = 6;
  localparam int          DBW_IO_MAX_LOG2 = 8;

  // ****************************************
  // bus slave states
  // ****************************************
  typedef enum logic [1:0] {
    DBW_ST_IDLE = 2'b00,
    DBW_ST_ACC  = 2'b01
  } dbw_bus_st_t;

endpackage

//--- src/dbw_win_if.sv
// carrier between the bank top and one window's register slice
// assumes a single clock; all signals are same-domain
`timescale 1ns/1ps
interface dbw_win_if;
  logic        wr_bar;
  logic        wr_setup;
  logic        wr_xlate;
  logic [31:0] wdata;
  logic [31:0] bar_val;
  logic [31:0] setup_val;
  logic [31:0] xlate_val;
  logic        enable;
  logic        is_io;
  logic [1:0]  io_len;
  logic [19:0] base;
  logic [19:0] mask;
  logic [19:0] xbase;

  modport top (output wr_bar, wr_setup, wr_xlate, wdata,
               input  bar_val, setup_val, xlate_val, enable, is_io, io_len, base, mask, xbase);
  modport win (input  wr_bar, wr_setup, wr_xlate, wdata,
               output bar_val, setup_val, xlate_val, enable, is_io, io_len, base, mask, xbase);
endinterface

//--- src/dbw_window.sv
// one downstream window: setup, base and translated-base registers
// assumes write strobes are single-cycle and byte lanes already merged into wdata
`timescale 1ns/1ps
module dbw_window
  import dbw_pkg::*;
#(
  parameter bit IO_CAPABLE = 1'b1,
  parameter bit WIDE_OK    = 1'b1
) (
  input  wire logic i_clk_sys,
  input  wire logic i_rst_n,
  dbw_win_if.win    win
);

  logic [31:0] setup_q, setup_d;
  logic [19:0] base_q,  base_d;
  logic [31:0] xlate_q, xlate_d;
  logic [1:0]  atype;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    setup_d = setup_q;
    xlate_d = xlate_q;
    if (win.wr_setup) begin
      setup_d = win.wdata;
    end
    if (!IO_CAPABLE) begin
      setup_d[DBW_BIT_SPACE] = 1'b0;
    end
    if (win.wr_xlate) begin
      xlate_d = win.wdata;
    end
    // base bits follow the writable mask; unmasked bits stay zero
    if (win.wr_bar) begin
      base_d = win.wdata[31:DBW_BIT_BASE_LO] & setup_q[31:DBW_BIT_BASE_LO];
    end else begin
      base_d = base_q & setup_q[31:DBW_BIT_BASE_LO];
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      setup_q <= DBW_RST_SETUP;
      base_q  <= DBW_RST_BASE;
      xlate_q <= DBW_RST_XLATE;
    end else begin
      setup_q <= setup_d;
      base_q  <= base_d;
      xlate_q <= xlate_d;
    end
  end

  // ****************************************
  // read-only fields derived from setup
  // ****************************************
  always_comb begin
    atype = DBW_ATYPE_32;
    if (WIDE_OK && setup_q[DBW_BIT_ATYPE_LO +: 2] == DBW_ATYPE_64) begin
      atype = DBW_ATYPE_64;
    end
  end

  // reserved 11:4 read as zero space, width, prefetch from setup
  assign win.bar_val   = {base_q, 8'h00, setup_q[DBW_BIT_PREF], atype, setup_q[DBW_BIT_SPACE]};
  assign win.setup_val = setup_q;
  assign win.xlate_val = xlate_q;
  assign win.enable    = setup_q[DBW_BIT_ENABLE];
  assign win.is_io     = setup_q[DBW_BIT_SPACE];
  assign win.io_len    = setup_q[DBW_BIT_IOLEN_LO +: 2];
  assign win.base      = base_q;
  assign win.mask      = setup_q[31:DBW_BIT_BASE_LO];
  assign win.xbase     = xlate_q[31:DBW_BIT_BASE_LO];

endmodule

//--- src/dbw_xlate.sv
// hit detection and direct address translation for one window
// assumes the caller registers the results; purely combinational
`timescale 1ns/1ps
module dbw_xlate
  import dbw_pkg::*;
(
  input  wire logic        i_enable,
  input  wire logic        i_is_io,
  input  wire logic [1:0]  i_io_len,
  input  wire logic [19:0] i_base,
  input  wire logic [19:0] i_mask,
  input  wire logic [19:0] i_xbase,
  input  wire logic [31:0] i_addr,
  output logic             o_hit,
  output logic [31:0]      o_fwd
);

  logic        match;
  logic        io_in;
  logic [8:0]  io_size;

  always_comb begin
    // io length 64, 128 or 256 bytes; code 3 clamps to the largest
    case (i_io_len)
      2'h0:    io_size = 9'h040;
      2'h1:    io_size = 9'h080;
      default: io_size = 9'h100;
    endcase
    match = ((i_addr[31:DBW_BIT_BASE_LO] ^ i_base) & i_mask) == 20'h0_0000;
    io_in = {3'h0, i_addr[11:0]} < {6'h00, io_size};
    // zero base or cleared enable keeps the window dark
    o_hit = i_enable && (i_base != 20'h0_0000) && match && (!i_is_io || io_in);
    o_fwd = {(i_xbase & i_mask) | (i_addr[31:DBW_BIT_BASE_LO] & ~i_mask), i_addr[11:0]};
  end

endmodule

//--- src/dbw_regs.sv
// downstream window register bank top: APB slave, two windows, registered decode
// assumes APB master on i_clk_sys and a same-clock setup loader (serial rom, smbus, local cpu)
//
// Function
// - the first window reports decode width in bits 2:1 as 00 for 32-bit or 01 for 64-bit, other codes reserved.
// - the second window is 32-bit only and its decode-width field always reads 00.
// - bit 3 is a read-only prefetch flag, 1 for prefetchable, resetting to 0.
// - the first window's size and space type come from its setup register, not fixed values.
// - the first window's setup register sits at offset ACh and may also be loaded by a side loader.
// - clearing bit 31 of a setup register disables that window.
// - memory windows span 4KB to 2GB and io windows 64B to 256B.
// - base bits 31:12 are writable only where the matching setup bit is one.
// - hits in the first window forward a directly translated address using the register at A8h.
// - a zero base field disables decode, and the base resets to zero.
`timescale 1ns/1ps
module dbw_regs
  import dbw_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              i_clk_sys,
  input  wire logic              i_rst_n,
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [ADDR_W-1:0] i_paddr,
  input  wire logic [31:0]       i_pwdata,
  input  wire logic [3:0]        i_pstrb,
  output logic [31:0]            o_prdata,
  output logic                   o_pready,
  output logic                   o_pslverr,
  input  wire logic              i_ld_valid,
  input  wire logic              i_ld_sel,
  input  wire logic [31:0]       i_ld_data,
  input  wire logic [31:0]       i_dn_addr,
  output logic                   o_win1_hit,
  output logic [31:0]            o_win1_fwd,
  output logic                   o_win2_hit,
  output logic [31:0]            o_win2_fwd
);

  if (ADDR_W < 8) begin : g_chk
    $error("dbw_regs: ADDR_W must be at least 8");
  end

  dbw_win_if w1 ();
  dbw_win_if w2 ();

  dbw_bus_st_t st_q, st_d;
  logic [31:0] rdata_q, rdata_d;
  logic        err_q, err_d;
  logic        hit1_q, hit1_d, hit2_q, hit2_d;
  logic [31:0] fwd1_q, fwd1_d, fwd2_q, fwd2_d;
  logic [31:0] rd_mux;
  logic        mapped;
  logic        wr_go;
  logic [7:0]  off;
  logic [31:0] cur_word;
  logic [31:0] merged;
  logic [31:0] lane_mask;

  // ****************************************
  // address decode and read mux
  // ****************************************
  assign off = i_paddr[7:0];

  always_comb begin
    rd_mux = DBW_RD_NONE;
    mapped = 1'b1;
    if (ADDR_W > 8 && (i_paddr >> 8) != '0) begin
      mapped = 1'b0;
    end else begin
      case (off)
        DBW_OFF_WIN1_BAR:   rd_mux = w1.bar_val;
        DBW_OFF_WIN2_BAR:   rd_mux = w2.bar_val;
        DBW_OFF_WIN1_XLATE: rd_mux = w1.xlate_val;
        DBW_OFF_WIN1_SETUP: rd_mux = w1.setup_val;
        DBW_OFF_WIN2_XLATE: rd_mux = w2.xlate_val;
        DBW_OFF_WIN2_SETUP: rd_mux = w2.setup_val;
        default:            mapped = 1'b0;
      endcase
    end
  end

  // ****************************************
  // bus handshake: one wait-free access phase
  // ****************************************
  always_comb begin
    st_d    = st_q;
    rdata_d = rdata_q;
    err_d   = err_q;
    case (st_q)
      DBW_ST_IDLE: begin
        if (i_psel && !i_penable) begin
          st_d    = DBW_ST_ACC;
          // read data sampled in setup so it comes from a flop in access
          rdata_d = i_pwrite ? DBW_RD_NONE : rd_mux;
          err_d   = !mapped;
        end
      end
      DBW_ST_ACC: begin
        st_d    = DBW_ST_IDLE;
        rdata_d = DBW_RD_NONE;
        err_d   = 1'b0;
      end
      default: begin
        st_d = DBW_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q    <= DBW_ST_IDLE;
      rdata_q <= DBW_RD_NONE;
      err_q   <= 1'b0;
    end else begin
      st_q    <= st_d;
      rdata_q <= rdata_d;
      err_q   <= err_d;
    end
  end

  assign o_pready  = (st_q == DBW_ST_ACC);
  assign o_prdata  = rdata_q;
  assign o_pslverr = err_q & o_pready;
  assign wr_go     = i_psel && i_penable && o_pready && i_pwrite && !err_q;

  // ****************************************
  // byte-lane merge and write strobes
  // ****************************************
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      lane_mask[i*8 +: 8] = {8{i_pstrb[i]}};
    end
    case (off)
      DBW_OFF_WIN1_BAR:   cur_word = w1.bar_val;
      DBW_OFF_WIN2_BAR:   cur_word = w2.bar_val;
      DBW_OFF_WIN1_XLATE: cur_word = w1.xlate_val;
      DBW_OFF_WIN1_SETUP: cur_word = w1.setup_val;
      DBW_OFF_WIN2_XLATE: cur_word = w2.xlate_val;
      DBW_OFF_WIN2_SETUP: cur_word = w2.setup_val;
      default:            cur_word = DBW_RD_NONE;
    endcase
    merged = (i_pwdata & lane_mask) | (cur_word & ~lane_mask);
  end

  // side loader takes the setup register over a bus write in the same cycle
  assign w1.wr_bar   = wr_go && off == DBW_OFF_WIN1_BAR;
  assign w1.wr_xlate = wr_go && off == DBW_OFF_WIN1_XLATE;
  assign w1.wr_setup = (i_ld_valid && !i_ld_sel) || (wr_go && off == DBW_OFF_WIN1_SETUP);
  assign w1.wdata    = (i_ld_valid && !i_ld_sel) ? i_ld_data : merged;
  assign w2.wr_bar   = wr_go && off == DBW_OFF_WIN2_BAR;
  assign w2.wr_xlate = wr_go && off == DBW_OFF_WIN2_XLATE;
  assign w2.wr_setup = (i_ld_valid && i_ld_sel) || (wr_go && off == DBW_OFF_WIN2_SETUP);
  assign w2.wdata    = (i_ld_valid && i_ld_sel) ? i_ld_data : merged;

  // ****************************************
  // windows
  // ****************************************
  dbw_window #(.IO_CAPABLE(1'b1), .WIDE_OK(1'b1)) u_win1 (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (i_rst_n),
    .win       (w1)
  );

  dbw_window #(.IO_CAPABLE(1'b0), .WIDE_OK(1'b0)) u_win2 (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (i_rst_n),
    .win       (w2)
  );

  dbw_xlate u_xl1 (
    .i_enable (w1.enable),
    .i_is_io  (w1.is_io),
    .i_io_len (w1.io_len),
    .i_base   (w1.base),
    .i_mask   (w1.mask),
    .i_xbase  (w1.xbase),
    .i_addr   (i_dn_addr),
    .o_hit    (hit1_d),
    .o_fwd    (fwd1_d)
  );

  dbw_xlate u_xl2 (
    .i_enable (w2.enable),
    .i_is_io  (1'b0),
    .i_io_len (2'h0),
    .i_base   (w2.base),
    .i_mask   (w2.mask),
    .i_xbase  (w2.xbase),
    .i_addr   (i_dn_addr),
    .o_hit    (hit2_d),
    .o_fwd    (fwd2_d)
  );

  // ****************************************
  // registered decode outputs
  // ****************************************
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hit1_q <= 1'b0;
      hit2_q <= 1'b0;
      fwd1_q <= DBW_RD_NONE;
      fwd2_q <= DBW_RD_NONE;
    end else begin
      hit1_q <= hit1_d;
      hit2_q <= hit2_d;
      fwd1_q <= fwd1_d;
      fwd2_q <= fwd2_d;
    end
  end

  assign o_win1_hit = hit1_q;
  assign o_win1_fwd = fwd1_q;
  assign o_win2_hit = hit2_q;
  assign o_win2_fwd = fwd2_q;

  // ****************************************
  // assertions
  // ****************************************
  property p_rsvd_zero;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (o_pready && !i_pwrite && (off == DBW_OFF_WIN1_BAR || off == DBW_OFF_WIN2_BAR)) |-> o_prdata[11:4] == 8'h00;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("bar reserved bits not zero");

  property p_w2_narrow;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (o_pready && !i_pwrite && off == DBW_OFF_WIN2_BAR) |-> o_prdata[2:0] == 3'h0;
  endproperty
  a_w2_narrow: assert property (p_w2_narrow) else $error("window two not 32-bit memory");

  property p_w1_atype;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      w1.bar_val[2:1] == ((w1.setup_val[2:1] == DBW_ATYPE_64) ? DBW_ATYPE_64 : DBW_ATYPE_32);
  endproperty
  a_w1_atype: assert property (p_w1_atype) else $error("window one width field wrong");

  property p_flags;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      w1.bar_val[3] == w1.setup_val[3] && w1.bar_val[0] == w1.setup_val[0];
  endproperty
  a_flags: assert property (p_flags) else $error("space or prefetch flag mismatch");

  property p_base_write;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (w1.wr_bar && !w1.wr_setup) |=> w1.base == ($past(merged[31:12]) & $past(w1.mask));
  endproperty
  a_base_write: assert property (p_base_write) else $error("base write ignored mask");

  property p_disable;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      !w1.enable |=> !o_win1_hit;
  endproperty
  a_disable: assert property (p_disable) else $error("disabled window hit");

  property p_zero_base;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (w2.base == 20'h0_0000) |=> !o_win2_hit;
  endproperty
  a_zero_base: assert property (p_zero_base) else $error("zero base window hit");

  property p_xlate;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      hit1_d |=> o_win1_hit && o_win1_fwd[11:0] == $past(i_dn_addr[11:0]);
  endproperty
  a_xlate: assert property (p_xlate) else $error("forwarded offset lost");

  property p_io_span;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (w1.is_io && i_dn_addr[11:8] != 4'h0) |=> !o_win1_hit;
  endproperty
  a_io_span: assert property (p_io_span) else $error("io window beyond 256 bytes");

  property p_setup_ld;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (i_ld_valid && !i_ld_sel) |=> w1.setup_val == $past(i_ld_data);
  endproperty
  a_setup_ld: assert property (p_setup_ld) else $error("setup load not taken");

  property p_ready;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (i_psel && !i_penable && !o_pready) |=> o_pready ##1 !o_pready;
  endproperty
  a_ready: assert property (p_ready) else $error("access phase not one cycle");

  c_bar_wr:  cover property (@(posedge i_clk_sys) disable iff (!i_rst_n) w1.wr_bar);
  c_hit1:    cover property (@(posedge i_clk_sys) disable iff (!i_rst_n) o_win1_hit && w1.is_io);
  c_hit2:    cover property (@(posedge i_clk_sys) disable iff (!i_rst_n) o_win2_hit);
  c_unmap:   cover property (@(posedge i_clk_sys) disable iff (!i_rst_n) o_pslverr);

endmodule

//--- verif/dbw_ld_model.sv
// side setup loader model standing in for serial rom, smbus or local cpu
// assumes the same clock as the bank; drives at the rising edge only
`timescale 1ns/1ps
module dbw_ld_model (
  input  wire logic        i_clk_sys,
  output logic             o_ld_valid,
  output logic             o_ld_sel,
  output logic [31:0]      o_ld_data
);
  initial begin
    o_ld_valid = 1'b0;
    o_ld_sel   = 1'b0;
    o_ld_data  = 32'h0000_0000;
  end

  // one-cycle load; data inverted after so a stale value never passes
  task automatic load(input logic sel, input logic [31:0] d);
    @(posedge i_clk_sys);
    o_ld_valid <= 1'b1;
    o_ld_sel   <= sel;
    o_ld_data  <= d;
    @(posedge i_clk_sys);
    o_ld_valid <= 1'b0;
    o_ld_data  <= ~d;
  endtask
endmodule

//--- verif/tb.sv
// self-checking bench for the downstream window register bank
// assumes an apb slave of bounded latency and a registered one-cycle address decode
`timescale 1ns/1ps
module tb;
  import dbw_pkg::*;
  logic        i_clk_sys;
  logic        i_rst_n;
  logic        psel, penable, pwrite, pready, pslverr;
  logic        ld_valid, ld_sel, win1_hit, win2_hit;
  logic [7:0]  paddr;
  logic [3:0]  pstrb;
  logic [31:0] pwdata, prdata, ld_data, dn_addr, win1_fwd, win2_fwd;
  int          n_mismatch;
  int          num_checks;

  initial begin
    i_clk_sys = 1'b0;
    forever #2.5 i_clk_sys = ~i_clk_sys;
  end

  dbw_regs #(.ADDR_W(8)) i_dut (
    .i_clk_sys (i_clk_sys), .i_rst_n (i_rst_n), .i_psel (psel), .i_penable (penable),
    .i_pwrite (pwrite), .i_paddr (paddr), .i_pwdata (pwdata), .i_pstrb (pstrb),
    .o_prdata (prdata), .o_pready (pready), .o_pslverr (pslverr), .i_ld_valid (ld_valid),
    .i_ld_sel (ld_sel), .i_ld_data (ld_data), .i_dn_addr (dn_addr), .o_win1_hit (win1_hit),
    .o_win1_fwd (win1_fwd), .o_win2_hit (win2_hit), .o_win2_fwd (win2_fwd)
  );

  dbw_ld_model i_ld (
    .i_clk_sys (i_clk_sys), .o_ld_valid (ld_valid), .o_ld_sel (ld_sel), .o_ld_data (ld_data)
  );

  // ****************************************
  // reporting
  // ****************************************
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // ****************************************
  // apb master and decode probe
  // ****************************************
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int i;
    q = 32'h0000_0000;
    e = 1'b0;
    @(posedge i_clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= 4'hF;
    @(posedge i_clk_sys);
    penable <= 1'b1;
    i = 0;
    // answer taken at the rising edge that completes the access, then released
    do begin
      @(posedge i_clk_sys);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1) begin
      n_mismatch++;
      $display("CHECK FAILED pready expected 1 seen %b", pready);
      report_and_stop();
    end else begin
      q       = prdata;
      e       = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0000_0000, q, e);
    chk(what, q, exp);
    chk("pslverr", {31'h0, e}, 32'h0000_0000);
  endtask

  task automatic dn(input logic [31:0] a, input logic h1, input logic [31:0] f1, input logic h2);
    @(posedge i_clk_sys);
    dn_addr <= a;
    @(posedge i_clk_sys);
    #1;
    chk("win1_hit", {31'h0, win1_hit}, {31'h0, h1});
    chk("win2_hit", {31'h0, win2_hit}, {31'h0, h2});
    if (h1) chk("win1_fwd", win1_fwd, f1);
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    logic [31:0] q;
    logic        e;
    i_rst_n    = 1'b0;
    psel       = 1'b0;
    penable    = 1'b0;
    pwrite     = 1'b0;
    paddr      = 8'h00;
    pwdata     = 32'h0000_0000;
    pstrb      = 4'h0;
    dn_addr    = 32'h0000_0000;
    n_mismatch = 0;
    num_checks = 0;
    repeat (4) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;

    rdc("bar1", DBW_OFF_WIN1_BAR, 32'h0000_0000);
    rdc("bar2", DBW_OFF_WIN2_BAR, 32'h0000_0000);
    wr(DBW_OFF_WIN1_BAR, 32'hFFFF_FFFF);
    rdc("bar1", DBW_OFF_WIN1_BAR, 32'h0000_0000);
    $display("test reset done");

    i_ld.load(1'b0, 32'hFFFF_F00A);
    rdc("setup1", DBW_OFF_WIN1_SETUP, 32'hFFFF_F00A);
    i_ld.load(1'b1, 32'hFFFF_F00F);
    rdc("setup2", DBW_OFF_WIN2_SETUP, 32'hFFFF_F00E);
    wr(DBW_OFF_WIN1_BAR, 32'hFFFF_FFFF);
    rdc("bar1", DBW_OFF_WIN1_BAR, 32'hFFFF_F00A);
    for (int c = 0; c < 4; c++) begin
      wr(DBW_OFF_WIN1_SETUP, 32'hFFFF_F000 | (c << 1));
      rdc("bar1", DBW_OFF_WIN1_BAR, (c == 1) ? 32'hFFFF_F002 : 32'hFFFF_F000);
      wr(DBW_OFF_WIN2_SETUP, 32'hFFFF_F009 | (c << 1));
      rdc("bar2", DBW_OFF_WIN2_BAR, 32'h0000_0008);
    end
    wr(DBW_OFF_WIN1_SETUP, 32'h8000_F000);
    rdc("bar1", DBW_OFF_WIN1_BAR, 32'h8000_F000);
    wr(DBW_OFF_WIN1_BAR, 32'h1234_5678);
    rdc("bar1", DBW_OFF_WIN1_BAR, 32'h0000_5000);
    $display("test fields done");

    wr(DBW_OFF_WIN1_SETUP, 32'hFFFF_0000);
    wr(DBW_OFF_WIN1_XLATE, 32'h1230_0000);
    wr(DBW_OFF_WIN1_BAR, 32'h4000_0000);
    rdc("bar1", DBW_OFF_WIN1_BAR, 32'h4000_0000);
    dn(32'h4000_ABCD, 1'b1, 32'h1230_ABCD, 1'b0);
    dn(32'h4001_0000, 1'b0, 32'h0000_0000, 1'b0);
    wr(DBW_OFF_WIN1_SETUP, 32'h7FFF_0000);
    dn(32'h4000_ABCD, 1'b0, 32'h0000_0000, 1'b0);
    wr(DBW_OFF_WIN1_SETUP, 32'hFFFF_0000);
    wr(DBW_OFF_WIN1_BAR, 32'h0000_0000);
    dn(32'h0000_1234, 1'b0, 32'h0000_0000, 1'b0);
    wr(DBW_OFF_WIN2_SETUP, 32'hFFFF_0000);
    wr(DBW_OFF_WIN2_BAR, 32'h2000_0000);
    wr(DBW_OFF_WIN2_XLATE, 32'h3000_0000);
    dn(32'h2000_0010, 1'b0, 32'h0000_0000, 1'b1);
    chk("win2_fwd", win2_fwd, 32'h3000_0010);
    $display("test memory decode done");

    wr(DBW_OFF_WIN1_SETUP, 32'hFFFF_F041);
    wr(DBW_OFF_WIN1_XLATE, 32'h5678_9000);
    wr(DBW_OFF_WIN1_BAR, 32'h1234_5000);
    rdc("bar1", DBW_OFF_WIN1_BAR, 32'h1234_5001);
    dn(32'h1234_507F, 1'b1, 32'h5678_907F, 1'b0);
    dn(32'h1234_5080, 1'b0, 32'h0000_0000, 1'b0);
    wr(DBW_OFF_WIN1_SETUP, 32'hFFFF_F081);
    dn(32'h1234_50FF, 1'b1, 32'h5678_90FF, 1'b0);
    wr(DBW_OFF_WIN1_SETUP, 32'hFFFF_F001);
    dn(32'h1234_503F, 1'b1, 32'h5678_903F, 1'b0);
    dn(32'h1234_5040, 1'b0, 32'h0000_0000, 1'b0);
    wr(DBW_OFF_WIN1_SETUP, 32'hFFFF_F0C1);
    dn(32'h1234_50FF, 1'b1, 32'h5678_90FF, 1'b0);
    dn(32'h1234_5100, 1'b0, 32'h0000_0000, 1'b0);
    $display("test io decode done");

    apb(1'b1, 8'h40, 32'hFFFF_FFFF, q, e);
    chk("pslverr", {31'h0, e}, 32'h0000_0001);
    apb(1'b0, 8'h40, 32'h0000_0000, q, e);
    chk("pslverr", {31'h0, e}, 32'h0000_0001);
    chk("unmapped", q, 32'h0000_0000);
    $display("test unmapped done");
    report_and_stop();
  end
endmodule
